// ---- logic/dbp_regs.svh ----
// Register offsets, delivery values, field limits and timing counts
// for the drive bus/position settings bank.
// Assumes register numbers are word addresses of the serial request layer.
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

// ------------------------------------------------------------------
// Register numbers
// ------------------------------------------------------------------
`define DBP_ADR_SPEED     16'h0027
`define DBP_ADR_IDLE      16'h0028
`define DBP_ADR_SPARE_LO  16'h0029
`define DBP_ADR_SPARE_HI  16'h002b
`define DBP_ADR_SENSE     16'h002c
`define DBP_ADR_NUMER     16'h002d
`define DBP_ADR_DENOM     16'h002e
`define DBP_ADR_GATE      16'h002f
`define DBP_ADR_REF_HI    16'h0030
`define DBP_ADR_REF_LO    16'h0031
`define DBP_ADR_SAVE      16'h0074

// ------------------------------------------------------------------
// Delivery values and value ranges
// ------------------------------------------------------------------
`define DBP_RST_SPEED     16'h0004
`define DBP_RST_IDLE      16'h0000
`define DBP_RST_SENSE     1'h0
`define DBP_RST_NUMER     16'h0190
`define DBP_RST_DENOM     16'h0190
`define DBP_RST_GATE      1'h0
`define DBP_RST_REF_HI    16'h0000
`define DBP_RST_BPS       17'h04b00
`define DBP_MAX_SPEED     16'h0008
`define DBP_MAX_IDLE      16'h2710
`define DBP_MIN_SCALE     16'h0001
`define DBP_MAX_SCALE     16'h2710
`define DBP_SAVE_CMD      16'h0001

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define DBP_CLK_HZ        200000000
`define DBP_MS_PER_S      1000
`define DBP_CYC_PER_MS    (`DBP_CLK_HZ / `DBP_MS_PER_S)

`endif

// ---- logic/dbp_pkg.sv ----
// Types shared by the settings bank and its helpers.
// Assumes the constants header is included by the design files.
package dbp_pkg;

   // Request header, presented once at the start of each request
   typedef struct packed {
      logic        is_write;
      logic [15:0] base;
      logic [7:0]  count;
   } dbp_req_t;

   // Backed-up settings image, exchanged with the store
   typedef struct packed {
      logic [15:0] speed_code;
      logic [15:0] idle_ms;
      logic        turn_sense;
      logic [15:0] numer;
      logic [15:0] denom;
      logic [15:0] ref_upper;
   } dbp_nv_t;

   // Live settings seen by the drive
   typedef struct packed {
      logic        turn_sense;
      logic [15:0] numer;
      logic [15:0] denom;
      logic [15:0] ref_upper;
      logic        ref_gate;
      logic [15:0] idle_ms;
   } dbp_cfg_t;

   // Speed code to bit rate
   function automatic logic [16:0] dbp_code_bps(input logic [15:0] code);
      logic [16:0] r;
      r = 17'h04b00;
      case (code)
         16'h0000: r = 17'h004b0;
         16'h0001: r = 17'h00960;
         16'h0002: r = 17'h012c0;
         16'h0003: r = 17'h02580;
         16'h0004: r = 17'h04b00;
         16'h0005: r = 17'h09600;
         16'h0006: r = 17'h0e100;
         16'h0007: r = 17'h12c00;
         16'h0008: r = 17'h1c200;
         default:  r = 17'h04b00;
      endcase
      return r;
   endfunction : dbp_code_bps

endpackage : dbp_pkg

// ---- logic/dbp_sync.sv ----
// Three-stage synchroniser for pin levels.
// Assumes the inputs are quasi-static switch levels.
`timescale 1ns/1ps
module dbp_sync #(
   parameter int unsigned W = 2
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Accept a change only once stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         level <= '0;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            level <= s3_r;
      end
   end
endmodule : dbp_sync

// ---- logic/dbp_idle_watch.sv ----
// Communication idle watchdog counting whole milliseconds.
// Assumes kick is a one-cycle pulse per valid request.
`timescale 1ns/1ps
module dbp_idle_watch #(
   parameter int unsigned CYC_PER_MS = 200000
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [15:0] limit_ms,
   input  wire logic        kick,
   output logic             expire
);
   localparam int unsigned PW = $clog2(CYC_PER_MS + 1);

   logic [PW-1:0] pre_r;
   logic [15:0]   ms_r;
   logic          armed_r;
   wire           off  = (limit_ms == 16'h0000);
   wire           tick = (pre_r == PW'(CYC_PER_MS - 1));
   wire           hit  = armed_r && tick && ((ms_r + 16'h0001) >= limit_ms);

   // Kick restarts the interval; zero limit parks everything
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pre_r   <= '0;
         ms_r    <= 16'h0000;
         armed_r <= 1'b0;
         expire  <= 1'b0;
      end
      else if (off)
      begin
         pre_r   <= '0;
         ms_r    <= 16'h0000;
         armed_r <= 1'b0;
         expire  <= 1'b0;
      end
      else if (kick)
      begin
         pre_r   <= '0;
         ms_r    <= 16'h0000;
         armed_r <= 1'b1;
         expire  <= 1'b0;
      end
      else
      begin
         pre_r   <= tick ? '0 : pre_r + PW'(1);
         ms_r    <= tick ? ms_r + 16'h0001 : ms_r;
         armed_r <= armed_r && !hit;
         expire  <= hit;
      end
   end
endmodule : dbp_idle_watch

// ---- logic/dbp_bank.sv ----
// Bus and position settings bank of the positioning drive.
// Assumes a request parser upstream that delivers a header, then one
// word strobe per register, then an end strobe with a validity flag,
// and a backed-up store that replays its image once after restart.
`timescale 1ns/1ps
`include "dbp_regs.svh"
module dbp_bank
   import dbp_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = `DBP_CYC_PER_MS
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        req_start,
   input  wire dbp_req_t    req_info,
   input  wire logic        wr_valid,
   input  wire logic [15:0] wr_addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        req_end,
   input  wire logic        req_ok,
   input  wire logic        rd_en,
   input  wire logic [15:0] rd_addr,
   output logic      [15:0] rd_data,
   output logic             rd_hit,
   output logic             rd_valid,
   output logic             wr_refused,
   input  wire logic [1:0]  speed_switch,
   input  wire logic        restore_load,
   input  wire dbp_nv_t     restore_img,
   output logic             save_req,
   output dbp_nv_t          save_img,
   output logic      [15:0] active_speed_code,
   output logic      [16:0] active_bps,
   output dbp_cfg_t         cfg,
   output logic             run_abort
);

   // ---------------------------------------------------------------
   // Switch input and request scope
   // ---------------------------------------------------------------
   logic [1:0]  switch_lvl;
   logic        ref_only_r;
   logic        ref_only_nxt;
   logic [16:0] last_addr;

   dbp_sync #(
      .W     (2)
   ) u_sw_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (speed_switch),
      .level (switch_lvl)
   );

   // Last register the request reaches; count of zero treated as one
   assign last_addr = {1'b0, req_info.base}
                    + {9'h000, req_info.count}
                    - ((req_info.count == 8'h00) ? 17'h00000 : 17'h00001);

   // Request touches nothing but the two offset words
   assign ref_only_nxt = (req_info.base >= `DBP_ADR_REF_HI) &&
                         (last_addr <= {1'b0, `DBP_ADR_REF_LO});

   // Scope flag is held for the whole request
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ref_only_r <= 1'b0;
      else if (req_start)
         ref_only_r <= ref_only_nxt;
   end

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   logic [15:0] speed_code_r;
   logic [15:0] idle_r;
   logic        sense_r;
   logic [15:0] numer_r;
   logic [15:0] denom_r;
   logic        gate_r;
   logic [15:0] ref_hi_r;
   logic [15:0] act_speed_r;

   wire sw_locked   = (switch_lvl != 2'b00);
   wire hit_speed   = wr_valid && (wr_addr == `DBP_ADR_SPEED);
   wire hit_idle    = wr_valid && (wr_addr == `DBP_ADR_IDLE);
   wire hit_sense   = wr_valid && (wr_addr == `DBP_ADR_SENSE);
   wire hit_numer   = wr_valid && (wr_addr == `DBP_ADR_NUMER);
   wire hit_denom   = wr_valid && (wr_addr == `DBP_ADR_DENOM);
   wire hit_gate    = wr_valid && (wr_addr == `DBP_ADR_GATE);
   wire hit_ref     = wr_valid && (wr_addr == `DBP_ADR_REF_HI);
   wire hit_save    = wr_valid && (wr_addr == `DBP_ADR_SAVE);

   // Range checks on each stored field but the offset, which needs request scope or the gate
   wire ok_speed    = (wr_data <= `DBP_MAX_SPEED) && !sw_locked;
   wire ok_idle     = (wr_data <= `DBP_MAX_IDLE);
   wire ok_bit      = (wr_data <= 16'h0001);
   wire ok_scale    = (wr_data >= `DBP_MIN_SCALE) &&
                      (wr_data <= `DBP_MAX_SCALE);
   wire ok_ref      = ref_only_r || gate_r;

   wire do_speed    = hit_speed && ok_speed;
   wire do_idle     = hit_idle  && ok_idle;
   wire do_sense    = hit_sense && ok_bit;
   wire do_numer    = hit_numer && ok_scale;
   wire do_denom    = hit_denom && ok_scale;
   wire do_gate     = hit_gate  && ok_bit;
   wire do_ref      = hit_ref   && ok_ref;
   wire do_save     = hit_save  && (wr_data == `DBP_SAVE_CMD);

   // A strobe aimed here that changed nothing
   wire refused_nxt = (hit_speed && !ok_speed) || (hit_idle && !ok_idle) ||
                      (hit_sense && !ok_bit)   || (hit_numer && !ok_scale) ||
                      (hit_denom && !ok_scale) || (hit_gate && !ok_bit)   ||
                      (hit_ref && !ok_ref);

   // ---------------------------------------------------------------
   // Settings registers
   // ---------------------------------------------------------------
   // Restore after restart wins; it only comes before any request
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         speed_code_r <= `DBP_RST_SPEED;
         idle_r       <= `DBP_RST_IDLE;
         sense_r      <= `DBP_RST_SENSE;
         numer_r      <= `DBP_RST_NUMER;
         denom_r      <= `DBP_RST_DENOM;
      end
      else if (restore_load)
      begin
         speed_code_r <= (restore_img.speed_code <= `DBP_MAX_SPEED) ?
                         restore_img.speed_code : `DBP_RST_SPEED;
         idle_r       <= restore_img.idle_ms;
         sense_r      <= restore_img.turn_sense;
         numer_r      <= restore_img.numer;
         denom_r      <= restore_img.denom;
      end
      else
      begin
         if (do_speed)
            speed_code_r <= wr_data;
         if (do_idle)
            idle_r <= wr_data;
         if (do_sense)
            sense_r <= wr_data[0];
         if (do_numer)
            numer_r <= wr_data;
         if (do_denom)
            denom_r <= wr_data;
      end
   end

   // Gate lives outside the store and always starts closed
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         gate_r <= `DBP_RST_GATE;
      else if (restore_load)
         gate_r <= `DBP_RST_GATE;
      else if (do_gate)
         gate_r <= wr_data[0];
   end

   // Upper half of the signed offset, bytes 3 and 2
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ref_hi_r <= `DBP_RST_REF_HI;
      else if (restore_load)
         ref_hi_r <= restore_img.ref_upper;
      else if (do_ref)
         ref_hi_r <= wr_data;
   end

   // Live speed follows the stored code only on restart, so a
   // written code cannot cut the link in the middle of a session
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         act_speed_r <= `DBP_RST_SPEED;
      else if (restore_load)
         act_speed_r <= (restore_img.speed_code <= `DBP_MAX_SPEED) ?
                        restore_img.speed_code : `DBP_RST_SPEED;
   end

   // Code to bit rate, registered
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         active_bps <= `DBP_RST_BPS;
      else
         active_bps <= dbp_code_bps(act_speed_r);
   end

   assign active_speed_code = act_speed_r;

   // ---------------------------------------------------------------
   // Save request to the backed-up store
   // ---------------------------------------------------------------
   dbp_nv_t img_now;

   assign img_now.speed_code = speed_code_r;
   assign img_now.idle_ms    = idle_r;
   assign img_now.turn_sense = sense_r;
   assign img_now.numer      = numer_r;
   assign img_now.denom      = denom_r;
   assign img_now.ref_upper  = ref_hi_r;

   // Snapshot taken with the save strobe; gate is never part of it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         save_req <= 1'b0;
         save_img <= '0;
      end
      else
      begin
         save_req <= do_save;
         if (do_save)
            save_img <= img_now;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [15:0] rd_mux;
   logic        rd_map;

   wire rd_spare = (rd_addr >= `DBP_ADR_SPARE_LO) &&
                   (rd_addr <= `DBP_ADR_SPARE_HI);

   // Spare words answer zero; foreign numbers report no hit
   always_comb
   begin
      rd_mux = 16'h0000;
      rd_map = 1'b1;
      case (rd_addr)
         `DBP_ADR_SPEED:  rd_mux = speed_code_r;
         `DBP_ADR_IDLE:   rd_mux = idle_r;
         `DBP_ADR_SENSE:  rd_mux = {15'h0000, sense_r};
         `DBP_ADR_NUMER:  rd_mux = numer_r;
         `DBP_ADR_DENOM:  rd_mux = denom_r;
         `DBP_ADR_GATE:   rd_mux = {15'h0000, gate_r};
         `DBP_ADR_REF_HI: rd_mux = ref_hi_r;
         default:         rd_map = rd_spare;
      endcase
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_data  <= 16'h0000;
         rd_hit   <= 1'b0;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en;
         if (rd_en)
         begin
            rd_data <= rd_mux;
            rd_hit  <= rd_map;
         end
      end
   end

   // ---------------------------------------------------------------
   // Refusal flag and live settings
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         wr_refused <= 1'b0;
      else
         wr_refused <= refused_nxt && !restore_load;
   end

   assign cfg.turn_sense = sense_r;
   assign cfg.numer      = numer_r;
   assign cfg.denom      = denom_r;
   assign cfg.ref_upper  = ref_hi_r;
   assign cfg.ref_gate   = gate_r;
   assign cfg.idle_ms    = idle_r;

   // ---------------------------------------------------------------
   // Communication timeout
   // ---------------------------------------------------------------
   // Only a well-formed request keeps the link alive
   wire kick = req_end && req_ok;

   dbp_idle_watch #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_idle (
      .clk        (clk),
      .rstn       (rstn),
      .limit_ms   (idle_r),
      .kick       (kick),
      .expire     (run_abort)
   );

endmodule : dbp_bank

// ---- tb/dbp_bank_assertions.sv ----
// Checker for the settings bank, bound to its top ports.
// Assumes CYC_PER_MS is 4, so 1 ms is 4 cycles.
`timescale 1ns/1ps
module dbp_bank_checker
   import dbp_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = 4
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        req_start,
   input wire dbp_req_t    req_info,
   input wire logic        wr_valid,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic        req_end,
   input wire logic        req_ok,
   input wire logic        wr_refused,
   input wire logic [1:0]  speed_switch,
   input wire logic        restore_load,
   input wire dbp_nv_t     restore_img,
   input wire logic        save_req,
   input wire logic [16:0] active_bps,
   input wire dbp_cfg_t    cfg,
   input wire logic        run_abort
);
   // ----------------
   // Request scope
   // ----------------
   logic        off_only_r;

   // Zero count is one word; offset-only: words 0x30..0x31
   wire [7:0]  cnt_nxt  = (req_info.count == 8'h00) ? 8'h01 : req_info.count;
   wire [15:0] last_nxt = req_info.base + {8'h00, cnt_nxt} - 16'h0001;
   wire        off_only_nxt = (req_info.base >= 16'h0030)
                              && (last_nxt <= 16'h0031);
   wire        kick = req_end && req_ok;

   // Scope held until the next request
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         off_only_r <= 1'b0;
      else if (req_start)
         off_only_r <= off_only_nxt;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------
   // Properties
   // ----------------
   a_speed_range: assert property (
      wr_valid && wr_addr == 16'h0027 && wr_data > 16'h0008 |=> wr_refused)
      else $error("speed code above 8 not refused");
   a_bps_code: assert property (
      restore_load && restore_img.speed_code == 16'h0000
      |-> ##2 active_bps == 17'h004b0)
      else $error("speed code 0 not 1200 bps");
   a_speed_switch: assert property (
      wr_valid && wr_addr == 16'h0027 && speed_switch != 2'b00
      && $past(speed_switch, 4) == speed_switch |=> wr_refused)
      else $error("speed write taken with switch set");
   a_save_trigger: assert property (
      wr_valid && wr_addr == 16'h0074 && wr_data == 16'h0001 |=> save_req)
      else $error("save word did not request save");
   a_idle_off: assert property (
      cfg.idle_ms == 16'h0000 && $past(cfg.idle_ms) == 16'h0000
      && $past(cfg.idle_ms, 2) == 16'h0000 |-> !run_abort)
      else $error("abort with supervision off");
   // 1 ms limit: abort 5 cycles after last kick
   a_abort_time: assert property (
      kick && cfg.idle_ms == 16'h0001 ##1
      (!kick && cfg.idle_ms == 16'h0001) [*4] |=> run_abort)
      else $error("abort missing after idle limit");
   a_turn_sense: assert property (
      wr_valid && wr_addr == 16'h002c && wr_data <= 16'h0001
      && !restore_load |=> {15'h0000, cfg.turn_sense} == $past(wr_data))
      else $error("turning sense not written");
   a_ref_apply: assert property (
      wr_valid && wr_addr == 16'h0030 && (off_only_r || cfg.ref_gate)
      && !restore_load |=> cfg.ref_upper == $past(wr_data))
      else $error("offset write not applied");
   a_ref_dropped: assert property (
      wr_valid && wr_addr == 16'h0030 && !off_only_r && !cfg.ref_gate
      |=> $stable(cfg.ref_upper))
      else $error("gated offset write applied");
   a_gate_restart: assert property (
      restore_load |=> !cfg.ref_gate)
      else $error("gate survived restart");
endmodule : dbp_bank_checker

bind dbp_bank dbp_bank_checker #(.CYC_PER_MS(CYC_PER_MS)) dbp_bank_checker_i (
   .clk(clk), .rstn(rstn), .req_start(req_start), .req_info(req_info),
   .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
   .req_end(req_end), .req_ok(req_ok), .wr_refused(wr_refused),
   .speed_switch(speed_switch), .restore_load(restore_load),
   .restore_img(restore_img), .save_req(save_req),
   .active_bps(active_bps), .cfg(cfg), .run_abort(run_abort));

// ---- tb/dbp_master_model.sv ----
// Bus master model issuing requests to the settings bank.
// Assumes the bank samples on the rising edge; drives 1 ns after it.
`timescale 1ns/1ps
module dbp_master_model
   import dbp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rd_valid,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_hit,
   output logic             req_start,
   output dbp_req_t         req_info,
   output logic             wr_valid,
   output logic      [15:0] wr_addr,
   output logic      [15:0] wr_data,
   output logic             req_end,
   output logic             req_ok,
   output logic             rd_en,
   output logic      [15:0] rd_addr
);
   // Idle bus at time zero
   initial
   begin
      {req_start, wr_valid, req_end, req_ok, rd_en} = 5'h00;
      {req_info, wr_addr, wr_data, rd_addr} = '0;
   end

   // Header, one word a cycle (w0, then w1), then end strobe
   task automatic write(input logic [15:0] base, input logic [7:0] cnt,
                        input logic [15:0] w0, input logic [15:0] w1,
                        input logic ok);
      @(posedge clk);
      #1;
      req_start = 1'b1;
      req_info = '{1'b1, base, cnt};
      for (int i = 0; i < cnt; i++)
      begin
         @(posedge clk);
         #1;
         req_start = 1'b0;
         wr_valid = 1'b1;
         wr_addr = base + 16'(i);
         wr_data = (i == 0) ? w0 : w1;
      end
      @(posedge clk);
      #1;
      req_start = 1'b0;
      wr_valid = 1'b0;
      // Released lines show the inverse
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
      req_end = 1'b1;
      req_ok = ok;
      @(posedge clk);
      #1;
      req_end = 1'b0;
      req_ok = 1'b0;
   endtask : write

   // Read strobe; answer is taken one edge later
   task automatic read(input logic [15:0] a, output logic [15:0] d,
                       output logic h, output logic v);
      @(posedge clk);
      #1;
      rd_en = 1'b1;
      rd_addr = a;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      rd_addr = ~a;
      d = rd_data;
      h = rd_hit;
      v = rd_valid;
   endtask : read
endmodule : dbp_master_model

// ---- tb/dbp_bank_test.sv ----
// Self-checking bench for the bus and position settings bank.
// Assumes a 200 MHz clock and a 4-cycle millisecond.
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module dbp_bank_test
   import dbp_pkg::*;
;
   logic        clk, rstn, req_start, wr_valid, req_end, req_ok, rd_en;
   logic        rd_hit, rd_valid, wr_refused, save_req, run_abort;
   logic        restore_load;
   logic [15:0] wr_addr, wr_data, rd_addr, rd_data, active_speed_code;
   logic [16:0] active_bps;
   logic [1:0]  speed_switch;
   dbp_req_t    req_info;
   dbp_nv_t     restore_img, save_img;
   dbp_cfg_t    cfg;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          n_abort = 0;

   // ----------------
   // Tables
   // ----------------
   localparam logic [15:0] RA [11] = '{16'h0027, 16'h0028, 16'h0029,
      16'h002b, 16'h002c, 16'h002d, 16'h002e, 16'h002f, 16'h0030,
      16'h0074, 16'h0040};
   localparam logic [15:0] RV [11] = '{16'h0004, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0190, 16'h0190, 16'h0, 16'h0, 16'h0, 16'h0};
   localparam logic [16:0] BPS [10] = '{17'h004b0, 17'h00960, 17'h012c0,
      17'h02580, 17'h04b00, 17'h09600, 17'h0e100, 17'h12c00, 17'h1c200,
      17'h04b00};
   localparam logic [15:0] FA [6] = '{16'h002d, 16'h002d, 16'h002d,
      16'h002e, 16'h002c, 16'h002c};
   localparam logic [15:0] FD [6] = '{16'h0000, 16'h2710, 16'h2711,
      16'h0096, 16'h0001, 16'h0002};
   localparam logic [15:0] FE [6] = '{16'h0190, 16'h2710, 16'h2710,
      16'h0096, 16'h0001, 16'h0001};

   dbp_bank #(.CYC_PER_MS(4)) dbp_bank_i (
      .clk(clk), .rstn(rstn), .req_start(req_start), .req_info(req_info),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
      .req_end(req_end), .req_ok(req_ok), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit),
      .rd_valid(rd_valid), .wr_refused(wr_refused),
      .speed_switch(speed_switch), .restore_load(restore_load),
      .restore_img(restore_img), .save_req(save_req),
      .save_img(save_img), .active_speed_code(active_speed_code),
      .active_bps(active_bps), .cfg(cfg), .run_abort(run_abort));

   dbp_master_model dbp_master_model_i (
      .clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit),
      .req_start(req_start), .req_info(req_info), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data), .req_end(req_end),
      .req_ok(req_ok), .rd_en(rd_en), .rd_addr(rd_addr));

   // Clock and abort pulse counter
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
      if (run_abort === 1'b1)
         n_abort++;

   // ----------------
   // Helpers
   // ----------------
   task automatic wr1(input logic [15:0] a, input logic [15:0] d);
      dbp_master_model_i.write(a, 8'h01, d, 16'h0000, 1'b1);
   endtask : wr1

   // Data judged only at mapped addresses
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e,
                         input logic eh);
      logic [15:0] d;
      logic        h, v;
      dbp_master_model_i.read(a, d, h, v);
      `CHK(v, 1'b1)
      `CHK(h, eh)
      if (eh)
         `CHK(d, e)
   endtask : rd_chk

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_defaults;
      for (int i = 0; i < 11; i++)
         rd_chk(RA[i], RV[i], 1'(i < 9));
      `CHK(active_bps, 17'h04b00)
   endtask : t_defaults

   // Each code, range refusal, switch refusal, save
   task automatic t_speed;
      for (int c = 0; c < 9; c++)
      begin
         wr1(16'h0027, 16'(c));
         rd_chk(16'h0027, 16'(c), 1'b1);
      end
      wr1(16'h0027, 16'h0009);
      rd_chk(16'h0027, 16'h0008, 1'b1);
      `CHK(active_speed_code, 16'h0004)
      for (int s = 1; s < 4; s++)
      begin
         @(posedge clk);
         #1;
         speed_switch = 2'(s);
         repeat (6) @(posedge clk);
         wr1(16'h0027, 16'h0002);
         rd_chk(16'h0027, 16'h0008, 1'b1);
      end
      speed_switch = 2'b00;
      wr1(16'h0074, 16'h0001);
      `CHK(save_img.speed_code, 16'h0008)
   endtask : t_speed

   // Restore each code; a set gate must drop
   task automatic t_restart;
      for (int c = 0; c < 10; c++)
      begin
         wr1(16'h002f, 16'h0001);
         @(posedge clk);
         #1;
         restore_img.speed_code = 16'(c);
         restore_load = 1'b1;
         @(posedge clk);
         #1;
         restore_load = 1'b0;
         @(posedge clk);
         #1;
         `CHK(active_speed_code, (c < 9) ? 16'(c) : 16'h0004)
         `CHK(active_bps, BPS[c])
         `CHK(cfg.ref_gate, 1'b0)
         `CHK(cfg.ref_upper, 16'h1234)
      end
   endtask : t_restart

   task automatic t_fields;
      for (int i = 0; i < 6; i++)
      begin
         wr1(FA[i], FD[i]);
         rd_chk(FA[i], FE[i], 1'b1);
      end
   endtask : t_fields

   task automatic t_reference;
      dbp_master_model_i.write(16'h002e, 8'h03, 16'h00c8, 16'h0, 1'b1);
      `CHK(cfg.denom, 16'h00c8)
      `CHK(cfg.ref_upper, 16'h1234)
      dbp_master_model_i.write(16'h0030, 8'h01, 16'h8001, 16'h0, 1'b1);
      rd_chk(16'h0030, 16'h8001, 1'b1);
      dbp_master_model_i.write(16'h0030, 8'h02, 16'h0007, 16'hffff, 1'b1);
      `CHK(cfg.ref_upper, 16'h0007)
      dbp_master_model_i.write(16'h002f, 8'h02, 16'h0001, 16'h0001, 1'b1);
      `CHK(cfg.ref_upper, 16'h0001)
   endtask : t_reference

   // Keep-alive every 4 cycles against a 4-cycle (1 ms) limit, then let it lapse
   task automatic t_timeout;
      wr1(16'h0028, 16'h0000);
      repeat (30) @(posedge clk);
      `CHK(n_abort, 0)
      wr1(16'h0028, 16'h0001);
      repeat (6) wr1(16'h002c, 16'h0000);
      `CHK(n_abort, 0)
      repeat (2) dbp_master_model_i.write(16'h002c, 8'h01, 16'h0, 16'h0, 1'b0);
      repeat (20) @(posedge clk);
      `CHK(n_abort, 1)
      wr1(16'h0028, 16'h0000);
      repeat (30) @(posedge clk);
      `CHK(n_abort, 1)
   endtask : t_timeout

   // Main sequence
   initial
   begin
      rstn = 1'b0;
      speed_switch = 2'b00;
      restore_load = 1'b0;
      restore_img = '{16'h0004, 16'h0000, 1'b0, 16'h0190, 16'h0190,
                      16'h1234};
      repeat (6) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_defaults();
      t_speed();
      t_restart();
      t_fields();
      t_reference();
      t_timeout();
      final_report();
   end

   // Watchdog: the run needs about 400 cycles
   initial
   begin
      #40000;
      n_mismatch++;
      final_report();
   end
endmodule : dbp_bank_test
